// file: rtl/dacr_map.svh
// dacr_map.svh: offsets, field positions, reset values for the dual converter control block
// assumes an 8-bit special function register port with an 8-bit address
`ifndef DACR_MAP_SVH
`define DACR_MAP_SVH
`define DACR_PRI_CTRL_ADDR   8'hd2
`define DACR_AUX_CTRL_ADDR   8'hd3
`define DACR_PRI_RES_L_ADDR  8'hd9
`define DACR_PRI_RES_M_ADDR  8'hda
`define DACR_PRI_RES_H_ADDR  8'hdb
`define DACR_PRI_CTRL_RST    8'h07
`define DACR_AUX_CTRL_RST    8'h00
`define DACR_PRI_CTRL_MASK   8'h7f
`define DACR_AUX_CTRL_MASK   8'h78
`define DACR_EXT_REF_BIT     6
`define DACR_CHAN_HI_BIT     5
`define DACR_CHAN_LO_BIT     4
`define DACR_UNIPOLAR_BIT    3
`define DACR_RANGE_HI_BIT    2
`define DACR_RANGE_LO_BIT    0
`define DACR_TEMP_ZERO_CODE  16'h8000
`define DACR_PRI_BIPOLAR_MID 24'h800000
`endif

// file: rtl/dacr_pkg.sv
// dacr_pkg.sv: types shared by the dual converter control block
// assumes dacr_map.svh supplies the numeric constants
package dacr_pkg;
  typedef enum logic [1:0] {DACR_PRI_ANALOG_INPUT_ONE_ANALOG_INPUT_TWO, DACR_PRI_ANALOG_INPUT_THREE_ANALOG_INPUT_FOUR,
                            DACR_PRI_SHORT_ANALOG_INPUT_TWO, DACR_PRI_ANALOG_INPUT_THREE_ANALOG_INPUT_TWO} dacr_pri_chan_e;
  typedef enum logic [1:0] {DACR_AUX_ANALOG_INPUT_THREE, DACR_AUX_ANALOG_INPUT_FOUR,
                            DACR_AUX_TEMP, DACR_AUX_ANALOG_INPUT_FIVE} dacr_aux_chan_e;
  typedef logic [2:0] dacr_range_t;
  typedef logic [7:0] dacr_byte_t;
endpackage

// file: rtl/dacr_aux_cal.sv
// dacr_aux_cal.sv: auxiliary calibration completion handling
// assumes the analog side pulses i_cal_done at the end of an auxiliary calibration
`timescale 1ns/1ps
`include "dacr_map.svh"
module dacr_aux_cal (
  input  wire logic i_sys_clk,
  input  wire logic i_srst,
  input  wire logic i_ce,
  input  wire logic i_cal_done,
  input  wire logic i_temp_sel,
  input  wire logic i_clear,
  output logic      o_ready,
  output logic      o_error,
  output logic      o_coef_wr
);
  logic ready_q, ready_d, error_q, error_d, coef_q, coef_d;

  always_comb begin
    ready_d = ready_q;
    error_d = error_q;
    coef_d  = 1'b0;
    if (i_clear) begin
      ready_d = 1'b0;
      error_d = 1'b0;
    end
    // completion wins over a clear in the same cycle
    if (i_cal_done) begin
      ready_d = 1'b1;
      error_d = i_temp_sel;
      coef_d  = ~i_temp_sel;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      ready_q <= 1'b0;
      error_q <= 1'b0;
      coef_q  <= 1'b0;
    end else if (i_ce) begin
      ready_q <= ready_d;
      error_q <= error_d;
      coef_q  <= coef_d;
    end
  end

  assign o_ready   = ready_q;
  assign o_error   = error_q;
  assign o_coef_wr = coef_q;
endmodule

// file: rtl/dacr_top.sv
// dacr_top.sv: control and result registers of the dual converter
// assumes a same-clock special function register port and a converter core on i_sys_clk
`timescale 1ns/1ps
`include "dacr_map.svh"
module dacr_top (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_srst,
  input  wire logic                    i_ce,
  input  wire logic [7:0]              i_sfr_addr,
  input  wire logic                    i_sfr_wr,
  input  wire logic                    i_sfr_rd,
  input  wire dacr_pkg::dacr_byte_t    i_sfr_wdata,
  input  wire logic                    i_primary_conv_enable,
  input  wire logic                    i_aux_conv_enable,
  input  wire logic                    i_pri_result_valid,
  input  wire logic [23:0]             i_pri_result,
  input  wire logic                    i_aux_cal_done,
  input  wire logic                    i_aux_cal_start,
  output dacr_pkg::dacr_byte_t         o_sfr_rdata,
  output logic                         o_primary_ext_ref_select,
  output dacr_pkg::dacr_pri_chan_e     o_primary_chan,
  output logic                         o_primary_unipolar,
  output dacr_pkg::dacr_range_t        o_primary_range,
  output logic                         o_aux_ext_ref_select,
  output dacr_pkg::dacr_aux_chan_e     o_aux_chan,
  output logic                         o_aux_unipolar,
  output logic                         o_aux_temp_sel,
  output logic [23:0]                  o_pri_zero_code,
  output logic [15:0]                  o_aux_zero_code,
  output logic                         o_pri_conv_reset,
  output logic                         o_aux_conv_reset,
  output logic                         o_aux_ready_flag,
  output logic                         o_aux_error_flag,
  output logic                         o_aux_coef_wr
);
  import dacr_pkg::*;

  dacr_byte_t pri_ctrl_q, pri_ctrl_d, aux_ctrl_q, aux_ctrl_d;
  logic [23:0] result_q, result_d;
  dacr_byte_t rdata_q, rdata_d;
  logic pri_en_q, aux_en_q;
  logic pri_rst_q, pri_rst_d, aux_rst_q, aux_rst_d;
  logic [23:0] pri_zero_q, pri_zero_d;
  logic [15:0] aux_zero_q, aux_zero_d;
  logic temp_sel_q, temp_sel_d;
  logic pri_wr, aux_wr;
  logic aux_ready, aux_error, aux_coef;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
    hit = (a == base);
  endfunction

  assign pri_wr = i_sfr_wr && hit(i_sfr_addr, `DACR_PRI_CTRL_ADDR);
  assign aux_wr = i_sfr_wr && hit(i_sfr_addr, `DACR_AUX_CTRL_ADDR);

  always_comb begin
    pri_ctrl_d = pri_ctrl_q;
    aux_ctrl_d = aux_ctrl_q;
    result_d   = result_q;
    if (pri_wr) begin
      pri_ctrl_d = i_sfr_wdata & `DACR_PRI_CTRL_MASK;
    end
    if (aux_wr) begin
      aux_ctrl_d = i_sfr_wdata & `DACR_AUX_CTRL_MASK;
    end
    if (i_pri_result_valid) begin
      result_d = i_pri_result;
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    if (i_sfr_rd) begin
      if (hit(i_sfr_addr, `DACR_PRI_CTRL_ADDR)) begin
        rdata_d = pri_ctrl_q;
      end else if (hit(i_sfr_addr, `DACR_AUX_CTRL_ADDR)) begin
        rdata_d = aux_ctrl_q;
      end else if (hit(i_sfr_addr, `DACR_PRI_RES_L_ADDR)) begin
        rdata_d = result_q[7:0];
      end else if (hit(i_sfr_addr, `DACR_PRI_RES_M_ADDR)) begin
        rdata_d = result_q[15:8];
      end else if (hit(i_sfr_addr, `DACR_PRI_RES_H_ADDR)) begin
        rdata_d = result_q[23:16];
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  // converter resets are one-cycle pulses; a primary reset also resets the auxiliary converter
  always_comb begin
    pri_rst_d = (pri_wr && i_primary_conv_enable) ||
                (i_primary_conv_enable && !pri_en_q);
    aux_rst_d = pri_rst_d || aux_wr ||
                (i_aux_conv_enable && !aux_en_q);
  end

  // zero-input codes follow the coding bits; the sensor reads 8000h at zero degrees
  always_comb begin
    pri_zero_d = pri_ctrl_d[`DACR_UNIPOLAR_BIT] ? 24'h000000 : `DACR_PRI_BIPOLAR_MID;
    aux_zero_d = aux_ctrl_d[`DACR_UNIPOLAR_BIT] ? 16'h0000   : 16'h8000;
    temp_sel_d = (aux_ctrl_d[`DACR_CHAN_HI_BIT:`DACR_CHAN_LO_BIT] == 2'(DACR_AUX_TEMP));
    if (temp_sel_d) begin
      aux_zero_d = `DACR_TEMP_ZERO_CODE;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      pri_ctrl_q <= `DACR_PRI_CTRL_RST;
      aux_ctrl_q <= `DACR_AUX_CTRL_RST;
      result_q   <= 24'h000000;
      rdata_q    <= 8'h00;
      pri_en_q   <= 1'b0;
      aux_en_q   <= 1'b0;
      pri_rst_q  <= 1'b0;
      aux_rst_q  <= 1'b0;
      pri_zero_q <= `DACR_PRI_BIPOLAR_MID;
      aux_zero_q <= 16'h8000;
      temp_sel_q <= 1'b0;
    end else if (i_ce) begin
      pri_ctrl_q <= pri_ctrl_d;
      aux_ctrl_q <= aux_ctrl_d;
      result_q   <= result_d;
      rdata_q    <= rdata_d;
      pri_en_q   <= i_primary_conv_enable;
      aux_en_q   <= i_aux_conv_enable;
      pri_rst_q  <= pri_rst_d;
      aux_rst_q  <= aux_rst_d;
      pri_zero_q <= pri_zero_d;
      aux_zero_q <= aux_zero_d;
      temp_sel_q <= temp_sel_d;
    end
  end

  // software must pair the sensor with internal reference and bipolar coding; not enforced
  dacr_aux_cal u_aux_cal (
    .i_sys_clk  (i_sys_clk),
    .i_srst     (i_srst),
    .i_ce       (i_ce),
    .i_cal_done (i_aux_cal_done),
    .i_temp_sel (aux_ctrl_q[`DACR_CHAN_HI_BIT:`DACR_CHAN_LO_BIT] == 2'(DACR_AUX_TEMP)),
    .i_clear    (i_aux_cal_start),
    .o_ready    (aux_ready),
    .o_error    (aux_error),
    .o_coef_wr  (aux_coef)
  );

  assign o_sfr_rdata              = rdata_q;
  assign o_primary_ext_ref_select = pri_ctrl_q[`DACR_EXT_REF_BIT];
  assign o_primary_chan           = dacr_pri_chan_e'(pri_ctrl_q[`DACR_CHAN_HI_BIT:`DACR_CHAN_LO_BIT]);
  assign o_primary_unipolar       = pri_ctrl_q[`DACR_UNIPOLAR_BIT];
  assign o_primary_range          = pri_ctrl_q[`DACR_RANGE_HI_BIT:`DACR_RANGE_LO_BIT];
  assign o_aux_ext_ref_select     = aux_ctrl_q[`DACR_EXT_REF_BIT];
  assign o_aux_chan               = dacr_aux_chan_e'(aux_ctrl_q[`DACR_CHAN_HI_BIT:`DACR_CHAN_LO_BIT]);
  assign o_aux_unipolar           = aux_ctrl_q[`DACR_UNIPOLAR_BIT];
  // no range field on the auxiliary side: span is always the reference
  assign o_aux_temp_sel           = temp_sel_q;
  assign o_pri_zero_code          = pri_zero_q;
  assign o_aux_zero_code          = aux_zero_q;
  assign o_pri_conv_reset         = pri_rst_q;
  assign o_aux_conv_reset         = aux_rst_q;
  assign o_aux_ready_flag         = aux_ready;
  assign o_aux_error_flag         = aux_error;
  assign o_aux_coef_wr            = aux_coef;
endmodule

// file: tb/dacr_props.sv
// dacr_props.sv: assertions on the ports of the dual converter control block
// assumes bind into dacr_top, one clock, i_srst synchronous active high
`timescale 1ns/1ps
module dacr_props (
  input wire logic                     i_sys_clk,
  input wire logic                     i_srst,
  input wire logic                     i_ce,
  input wire logic [7:0]               i_sfr_addr,
  input wire logic                     i_sfr_wr,
  input wire logic                     i_sfr_rd,
  input wire dacr_pkg::dacr_byte_t     i_sfr_wdata,
  input wire logic                     i_primary_conv_enable,
  input wire logic                     i_aux_cal_done,
  input wire dacr_pkg::dacr_byte_t     o_sfr_rdata,
  input wire logic                     o_primary_ext_ref_select,
  input wire dacr_pkg::dacr_pri_chan_e o_primary_chan,
  input wire logic                     o_primary_unipolar,
  input wire dacr_pkg::dacr_range_t    o_primary_range,
  input wire logic                     o_aux_temp_sel,
  input wire logic [23:0]              o_pri_zero_code,
  input wire logic                     o_pri_conv_reset,
  input wire logic                     o_aux_conv_reset,
  input wire logic                     o_aux_ready_flag,
  input wire logic                     o_aux_error_flag,
  input wire logic                     o_aux_coef_wr
);
  import dacr_pkg::*;
  logic pri_wr;
  logic aux_wr;
  assign pri_wr = i_ce && i_sfr_wr && i_sfr_addr == 8'hd2;
  assign aux_wr = i_ce && i_sfr_wr && i_sfr_addr == 8'hd3;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  a_pri_ref_field: assert property (pri_wr |=> o_primary_ext_ref_select == $past(i_sfr_wdata[6]))
    else $error("primary reference select wrong");
  a_pri_chan_field: assert property (pri_wr |=> o_primary_chan == $past(i_sfr_wdata[5:4]))
    else $error("primary channel wrong");
  a_pri_zero_code: assert property (o_pri_zero_code == (o_primary_unipolar ? 24'h000000 : 24'h800000))
    else $error("primary zero code wrong");
  a_pri_range_field: assert property (pri_wr |=> o_primary_range == $past(i_sfr_wdata[2:0]))
    else $error("primary range wrong");
  a_unmapped_read_zero: assert property (i_ce && i_sfr_rd && !(i_sfr_addr inside {8'hd2, 8'hd3, 8'hd9, 8'hda, 8'hdb})
    |=> o_sfr_rdata == 8'h00) else $error("unmapped read not zero");
  a_pri_wr_resets: assert property (pri_wr && i_primary_conv_enable |=> o_pri_conv_reset && o_aux_conv_reset)
    else $error("primary write did not reset both");
  a_aux_wr_reset: assert property (aux_wr && !i_primary_conv_enable |=> o_aux_conv_reset && !o_pri_conv_reset)
    else $error("aux write reset wrong");
  a_cal_done_flags: assert property (i_ce && i_aux_cal_done |=> o_aux_ready_flag &&
    o_aux_error_flag == $past(o_aux_temp_sel) && o_aux_coef_wr != $past(o_aux_temp_sel)) else $error("cal flags wrong");
  cover property (pri_wr && i_primary_conv_enable);
  cover property (i_aux_cal_done && o_aux_temp_sel);
  cover property (aux_wr && !i_primary_conv_enable);
endmodule
bind dacr_top dacr_props i_props (.*);

// file: tb/test_dual_adc_config_and_result_regs.sv
// test_dual_adc_config_and_result_regs.sv: random and corner tests of the converter control block
// assumes dacr_top with dacr_props bound in; inputs move on the falling edge
`timescale 1ns/1ps
module test_dual_adc_config_and_result_regs;
  import dacr_pkg::*;
  logic i_sys_clk = 0, i_srst = 1, i_ce = 1, i_sfr_wr = 0, i_sfr_rd = 0, i_pri_result_valid = 0;
  logic i_primary_conv_enable = 0, i_aux_conv_enable = 0, i_aux_cal_done = 0, i_aux_cal_start = 0;
  logic [7:0] i_sfr_addr = 0, i_sfr_wdata = 0, o_sfr_rdata, d;
  logic [23:0] i_pri_result = 0, o_pri_zero_code;
  logic [15:0] o_aux_zero_code;
  logic [31:0] seed = 32'hf135472f;
  dacr_pri_chan_e o_primary_chan;
  dacr_aux_chan_e o_aux_chan;
  dacr_range_t o_primary_range;
  logic o_primary_ext_ref_select, o_primary_unipolar, o_aux_ext_ref_select, o_aux_unipolar, o_aux_temp_sel;
  logic o_pri_conv_reset, o_aux_conv_reset, o_aux_ready_flag, o_aux_error_flag, o_aux_coef_wr;
  int miscompares = 0, total_checks = 0;
  dacr_top i_dut (.*);
  always #5 i_sys_clk = ~i_sys_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge i_sys_clk);
    s = 1;
    @(negedge i_sys_clk);
    s = 0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    i_sfr_addr = a;
    i_sfr_wdata = v;
    pulse(i_sfr_wr);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    i_sfr_addr = a;
    pulse(i_sfr_rd);
    chk(o_sfr_rdata, exp);
  endtask
  task automatic finish_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (3) @(negedge i_sys_clk);
    i_srst = 0;
    rreg(8'hd2, 8'h07);
    rreg(8'hd3, 8'h00);
    for (int a = 9; a < 12; a++) rreg(8'hd0 + 8'(a), 8'h00);
    // first pass all ones, so reserved bits are really offered a one
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      d = (i == 0) ? 8'hff : seed[7:0];
      i_primary_conv_enable = seed[8];
      i_aux_conv_enable = seed[9];
      wreg(8'hd2, d);
      chk(o_primary_ext_ref_select, d[6]);
      chk(o_primary_chan, d[5:4]);
      chk(o_pri_zero_code, d[3] ? 24'h0 : 24'h800000);
      chk(o_primary_range, d[2:0]);
      rreg(8'hd2, d & 8'h7f);
      wreg(8'hd3, d);
      chk({o_aux_ext_ref_select, o_aux_unipolar}, {d[6], d[3]});
      chk({o_aux_chan, o_aux_temp_sel}, {d[5:4], d[5:4] == 2'b10});
      chk(o_aux_zero_code, (d[5:4] == 2'b10 || !d[3]) ? 24'h8000 : 24'h0);
      rreg(8'hd3, d & 8'h78);
    end
    // frozen clock enable must keep the last written fields
    i_ce = 0;
    wreg(8'hd2, ~d);
    chk(o_primary_range, d[2:0]);
    i_ce = 1;
    i_primary_conv_enable = 1;
    i_aux_conv_enable = 1;
    repeat (2) @(negedge i_sys_clk);
    wreg(8'hd2, 8'h07);
    chk({o_pri_conv_reset, o_aux_conv_reset}, 2'b11);
    wreg(8'hd3, 8'h00);
    chk({o_pri_conv_reset, o_aux_conv_reset}, 2'b01);
    seed = lfsr(seed);
    i_pri_result = seed[23:0];
    pulse(i_pri_result_valid);
    wreg(8'hd9, 8'h5a);
    rreg(8'hd9, i_pri_result[7:0]);
    rreg(8'hda, i_pri_result[15:8]);
    rreg(8'hdb, i_pri_result[23:16]);
    rreg(8'hd4, 8'h00);
    wreg(8'hd3, 8'h20);
    pulse(i_aux_cal_done);
    chk({o_aux_ready_flag, o_aux_error_flag, o_aux_coef_wr}, 3'b110);
    pulse(i_aux_cal_start);
    chk({o_aux_ready_flag, o_aux_error_flag}, 2'b00);
    wreg(8'hd3, 8'h00);
    pulse(i_aux_cal_done);
    chk({o_aux_ready_flag, o_aux_error_flag, o_aux_coef_wr}, 3'b101);
    finish_test();
  end
endmodule
